// file: pdn_regs.sv
// Output buffer disable, global power-down mask and sync/reference control registers.
// Assumes the serial control port decodes frames into a one-cycle write or read strobe with address and data.
`timescale 1ns/1ps
module pdn_regs
	import pdn_regs_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	output logic      [DATA_W-1:0]   reg_rdata,
	input  wire logic                sync_or_sleep_pin,
	output logic      [B_LINES-1:0]  chan_b_line_off,
	output logic      [A_LINES-1:0]  chan_a_line_off,
	output logic                     frame_clock_out_off,
	output logic                     external_bit_clock_in_on,
	output logic                     data_clock_out_off,
	output logic                     whole_chip_sleep,
	output logic                     sample_clock_buffer_off,
	output logic                     reference_amplifier_off,
	output logic                     bandgap_off,
	output logic                     sync_pulse
);
	logic [7:0] ob_low;
	logic [7:0] ob_mid;
	logic [7:0] ob_high;
	logic [7:0] pdn_mask;
	logic [7:0] sync_ref;
	logic [7:0] pdn_ctrl;
	logic [7:0] clk_buf_ctrl;
	logic       wr_ob_low;
	logic       wr_ob_mid;
	logic       wr_ob_high;
	logic       wr_pdn_mask;
	logic       wr_sync_ref;
	logic       wr_pdn_ctrl;
	logic       wr_clk_buf_ctrl;
	logic       sleep_req;
	logic       sleep_reg;
	logic       sleep_next;
	logic [7:0] live_mask_reg;
	logic [7:0] live_mask_next;
	logic       sync_pin_reg;
	logic       sync_pin_next;
	logic       sync_pulse_reg;
	logic       sync_pulse_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// Address decode; a write to an unmapped address changes nothing.
	assign wr_ob_low       = reg_wr && (reg_addr == ADDR_OB_LOW);
	assign wr_ob_mid       = reg_wr && (reg_addr == ADDR_OB_MID);
	assign wr_ob_high      = reg_wr && (reg_addr == ADDR_OB_HIGH);
	assign wr_pdn_mask     = reg_wr && (reg_addr == ADDR_PDN_MASK);
	assign wr_sync_ref     = reg_wr && (reg_addr == ADDR_SYNC_REF);
	assign wr_pdn_ctrl     = reg_wr && (reg_addr == ADDR_PDN_CTRL);
	assign wr_clk_buf_ctrl = reg_wr && (reg_addr == ADDR_CLK_BUF_CTRL);

	cfg_byte_reg u_ob_low (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_ob_low),
		.wr_data  (reg_wdata),
		.value    (ob_low)
	);

	cfg_byte_reg u_ob_mid (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_ob_mid),
		.wr_data  (reg_wdata),
		.value    (ob_mid)
	);

	cfg_byte_reg u_ob_high (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_ob_high),
		.wr_data  (reg_wdata),
		.value    (ob_high)
	);

	cfg_byte_reg u_pdn_mask (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_pdn_mask),
		.wr_data  (reg_wdata),
		.value    (pdn_mask)
	);

	cfg_byte_reg u_sync_ref (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_sync_ref),
		.wr_data  (reg_wdata),
		.value    (sync_ref)
	);

	cfg_byte_reg u_pdn_ctrl (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_pdn_ctrl),
		.wr_data  (reg_wdata),
		.value    (pdn_ctrl)
	);

	cfg_byte_reg u_clk_buf_ctrl (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (wr_clk_buf_ctrl),
		.wr_data  (reg_wdata),
		.value    (clk_buf_ctrl)
	);

	// Driver power-down map; register bits with no pin are stored but drive nothing.
	always_comb begin
		chan_b_line_off[5] = ob_low[LOW_B5_BIT];
		chan_b_line_off[4] = ob_low[LOW_B4_BIT];
		chan_b_line_off[2] = ob_low[LOW_B2_BIT];
		chan_b_line_off[1] = ob_low[LOW_B1_BIT];
		chan_b_line_off[0] = ob_low[LOW_B0_BIT];
		chan_b_line_off[6] = ob_mid[MID_B6_BIT];
		chan_b_line_off[3] = ob_high[HIGH_B3_BIT];
		chan_a_line_off[4] = ob_mid[MID_A4_BIT];
		chan_a_line_off[2] = ob_mid[MID_A2_BIT];
		chan_a_line_off[1] = ob_mid[MID_A1_BIT];
		chan_a_line_off[0] = ob_mid[MID_A0_BIT];
		chan_a_line_off[3] = ob_high[HIGH_A3_BIT];
		chan_a_line_off[6] = ob_high[HIGH_A6_BIT];
		chan_a_line_off[5] = ob_high[HIGH_A5_BIT];
	end

	// The frame clock shares the channel-A line 1 driver in the serial modes.
	assign frame_clock_out_off = ob_mid[MID_A1_BIT];

	// The bit clock input and data clock output buffers follow their own register, never the disable bits.
	assign external_bit_clock_in_on = clk_buf_ctrl[BITCLK_IN_EN_BIT];
	assign data_clock_out_off       = clk_buf_ctrl[DATA_CLK_OUT_OFF_BIT];

	assign sleep_req = pdn_ctrl[SLEEP_BIT] || (!sync_ref[SYNC_PIN_EN_BIT] && sync_or_sleep_pin);

	always_comb begin
		sleep_next     = sleep_req;
		live_mask_next = live_mask_reg;
		// The mask is sampled only on entry so a change mid-sleep cannot glitch an analogue block.
		if (sleep_req && !sleep_reg) begin
			live_mask_next = pdn_mask;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_reg     <= 1'b0;
			live_mask_reg <= RESET_VALUE;
		end else begin
			sleep_reg     <= sleep_next;
			live_mask_reg <= live_mask_next;
		end
	end

	// The pin is taken as synchronous; its last sample gives the rising edge for the sync pulse.
	// The sample resets low, the pin's idle level, so no false pulse follows reset.
	always_comb begin
		sync_pin_next   = sync_or_sleep_pin;
		sync_pulse_next = sync_ref[SYNC_PIN_EN_BIT] && sync_or_sleep_pin && !sync_pin_reg;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_pin_reg   <= 1'b0;
			sync_pulse_reg <= 1'b0;
		end else begin
			sync_pin_reg   <= sync_pin_next;
			sync_pulse_reg <= sync_pulse_next;
		end
	end

	// Read data is registered and held until the next read strobe.
	always_comb begin
		rdata_next = rdata_reg;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_OB_LOW:       rdata_next = ob_low;
				ADDR_OB_MID:       rdata_next = ob_mid;
				ADDR_OB_HIGH:      rdata_next = ob_high;
				ADDR_PDN_MASK:     rdata_next = pdn_mask;
				ADDR_SYNC_REF:     rdata_next = sync_ref;
				ADDR_PDN_CTRL:     rdata_next = pdn_ctrl;
				ADDR_CLK_BUF_CTRL: rdata_next = clk_buf_ctrl;
				default:           rdata_next = RESET_VALUE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= RESET_VALUE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata               = rdata_reg;
	assign whole_chip_sleep        = sleep_reg;
	assign sync_pulse              = sync_pulse_reg;
	assign sample_clock_buffer_off = sleep_reg && !live_mask_reg[KEEP_CLK_BUF_BIT];
	assign reference_amplifier_off = sleep_reg && !live_mask_reg[KEEP_REF_AMP_BIT];
	// Inverse sense: a set bit lets sleep drop the bandgap, trading wake-up time for power.
	assign bandgap_off             = sleep_reg && live_mask_reg[BANDGAP_OFF_BIT];
endmodule : pdn_regs

// file: pdn_regs_pkg.sv
// Package with register offsets, reset values and field positions for the output buffer and power-down registers.
// Assumes an 8-bit serial-port register interface with a one-cycle write strobe.
package pdn_regs_pkg;
	localparam int unsigned ADDR_W        = 8;
	localparam int unsigned DATA_W        = 8;
	localparam logic [7:0]  ADDR_OB_LOW   = 8'h0a;
	localparam logic [7:0]  ADDR_OB_MID   = 8'h0b;
	localparam logic [7:0]  ADDR_OB_HIGH  = 8'h0c;
	localparam logic [7:0]  ADDR_PDN_MASK = 8'h0d;
	localparam logic [7:0]  ADDR_SYNC_REF = 8'h0e;
	localparam logic [7:0]  ADDR_PDN_CTRL = 8'h08;
	localparam logic [7:0]  ADDR_CLK_BUF_CTRL = 8'h1f;
	localparam logic [7:0]  RESET_VALUE   = 8'h00;
	localparam int unsigned KEEP_CLK_BUF_BIT = 3;
	localparam int unsigned KEEP_REF_AMP_BIT = 2;
	localparam int unsigned BANDGAP_OFF_BIT  = 1;
	localparam int unsigned SYNC_PIN_EN_BIT = 7;
	localparam int unsigned SLEEP_BIT       = 0;
	localparam int unsigned BITCLK_IN_EN_BIT = 6;
	localparam int unsigned DATA_CLK_OUT_OFF_BIT = 4;
	localparam int unsigned LOW_B5_BIT      = 7;
	localparam int unsigned LOW_B4_BIT      = 6;
	localparam int unsigned LOW_B2_BIT      = 4;
	localparam int unsigned LOW_B1_BIT      = 3;
	localparam int unsigned LOW_B0_BIT      = 2;
	localparam int unsigned MID_A4_BIT      = 7;
	localparam int unsigned MID_A2_BIT      = 5;
	localparam int unsigned MID_A1_BIT      = 4;
	localparam int unsigned MID_A0_BIT      = 3;
	localparam int unsigned MID_B6_BIT      = 0;
	localparam int unsigned HIGH_A3_BIT     = 3;
	localparam int unsigned HIGH_B3_BIT     = 2;
	localparam int unsigned HIGH_A6_BIT     = 1;
	localparam int unsigned HIGH_A5_BIT     = 0;
	localparam int unsigned B_LINES       = 7;
	localparam int unsigned A_LINES       = 7;
endpackage : pdn_regs_pkg

// file: cfg_byte_reg.sv
// One 8-bit read/write configuration register with asynchronous reset.
// Assumes the write strobe lasts one core_clk cycle per write.
`timescale 1ns/1ps
module cfg_byte_reg
	import pdn_regs_pkg::*;
#(
	parameter logic [7:0] RESET_VAL = RESET_VALUE
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] value
);
	logic [7:0] value_reg;
	logic [7:0] value_next;

	always_comb begin
		value_next = value_reg;
		if (wr_en) begin
			value_next = wr_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			value_reg <= RESET_VAL;
		end else begin
			value_reg <= value_next;
		end
	end

	assign value = value_reg;
endmodule : cfg_byte_reg

// file: pdn_regs_assertions.sv
// Checker for the register bank: line maps, sleep outputs and sync pulse at the ports.
// Assumes it is bound to pdn_regs and sees only its ports.
`timescale 1ns/1ps
module pdn_regs_assertions
	import pdn_regs_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       sync_or_sleep_pin,
	input wire logic [6:0] chan_b_line_off,
	input wire logic [6:0] chan_a_line_off,
	input wire logic       external_bit_clock_in_on,
	input wire logic       data_clock_out_off,
	input wire logic       whole_chip_sleep,
	input wire logic       sample_clock_buffer_off,
	input wire logic       reference_amplifier_off,
	input wire logic       bandgap_off,
	input wire logic       sync_pulse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_low_map: assert property (reg_wr && reg_addr == 8'h0a |=>
		{chan_b_line_off[5:4], chan_b_line_off[2:0]} == $past({reg_wdata[7:6], reg_wdata[4:2]})) else $error("low map");
	chk_mid_map: assert property (reg_wr && reg_addr == 8'h0b |=>
		{chan_a_line_off[4], chan_a_line_off[2:0], chan_b_line_off[6]} == $past({reg_wdata[7], reg_wdata[5:3], reg_wdata[0]}))
		else $error("mid map");
	chk_high_map: assert property (reg_wr && reg_addr == 8'h0c |=>
		{chan_a_line_off[3], chan_b_line_off[3], chan_a_line_off[6:5]} == $past(reg_wdata[3:0])) else $error("high map");
	chk_clk_ctl: assert property (reg_wr && reg_addr != 8'h1f |=>
		$stable(external_bit_clock_in_on) && $stable(data_clock_out_off)) else $error("clock control moved");
	chk_awake_on: assert property (!whole_chip_sleep |->
		!(sample_clock_buffer_off | reference_amplifier_off | bandgap_off)) else $error("block off while awake");
	chk_mask_hold: assert property (whole_chip_sleep && $past(whole_chip_sleep) |->
		$stable({sample_clock_buffer_off, reference_amplifier_off, bandgap_off})) else $error("mask changed in sleep");
	chk_rdata_hold: assert property (!reg_rd && !$past(reg_rd) |=> $stable(reg_rdata)) else $error("rdata moved");
	chk_sync_once: assert property (sync_pulse |=> !sync_pulse) else $error("sync pulse too long");
	chk_sync_cause: assert property (sync_pulse |-> $past(sync_or_sleep_pin)) else $error("sync without pin");
	cover property (reg_wr && reg_addr == 8'h0a);
	cover property ($rose(whole_chip_sleep));
	cover property (sync_pulse);
endmodule : pdn_regs_assertions
bind pdn_regs pdn_regs_assertions i_pdn_regs_assertions (.*);

// file: tb.sv
// Self-checking bench for the output buffer and power-down register bank.
// Assumes the one-cycle strobe register port; inputs change at the falling edge.
`timescale 1ns/1ps
module tb;
	import pdn_regs_pkg::*;
	logic        core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sync_or_sleep_pin = 0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [6:0]  chan_b_line_off, chan_a_line_off;
	logic        frame_clock_out_off, external_bit_clock_in_on, data_clock_out_off, whole_chip_sleep;
	logic        sample_clock_buffer_off, reference_amplifier_off, bandgap_off, sync_pulse;
	int          err_count = 0, checks = 0;
	logic [23:0] mode [4] = '{24'h2346f0, 24'h7feefc, 24'hffeefd, 24'hffeffd};
	wire  [3:0]  offs = {whole_chip_sleep, sample_clock_buffer_off, reference_amplifier_off, bandgap_off};
	pdn_regs i_pdn_regs (
		.core_clk                 (core_clk),
		.rst_n                    (rst_n),
		.reg_wr                   (reg_wr),
		.reg_rd                   (reg_rd),
		.reg_addr                 (reg_addr),
		.reg_wdata                (reg_wdata),
		.reg_rdata                (reg_rdata),
		.sync_or_sleep_pin        (sync_or_sleep_pin),
		.chan_b_line_off          (chan_b_line_off),
		.chan_a_line_off          (chan_a_line_off),
		.frame_clock_out_off      (frame_clock_out_off),
		.external_bit_clock_in_on (external_bit_clock_in_on),
		.data_clock_out_off       (data_clock_out_off),
		.whole_chip_sleep         (whole_chip_sleep),
		.sample_clock_buffer_off  (sample_clock_buffer_off),
		.reference_amplifier_off  (reference_amplifier_off),
		.bandgap_off              (bandgap_off),
		.sync_pulse               (sync_pulse)
	);
	always #50 core_clk = ~core_clk;
	task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge core_clk);
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge core_clk);
		reg_wr = 0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(negedge core_clk);
		{reg_rd, reg_addr} = {1'b1, a};
		@(negedge core_clk);
		reg_rd = 0;
		cmp("rdata", e, reg_rdata);
	endtask : rd
	task automatic t_reset;
		for (int i = 0; i < 5; i++) rd(8'h0a + 8'(i), 8'h00);
		rd(8'h55, 8'h00);
		cmp("lines", 8'h00, {chan_b_line_off, frame_clock_out_off});
		cmp("lines_a", 8'h00, {chan_a_line_off, external_bit_clock_in_on});
		cmp("idle", 8'h00, {2'h0, offs, data_clock_out_off, sync_pulse});
	endtask : t_reset
	// The recommended patterns never switch off A lines 1 and 6, so two extra writes cover those bits.
	task automatic t_modes;
		logic [7:0] l, m, h;
		foreach (mode[i]) begin
			{l, m, h} = mode[i];
			wr(8'h0a, l);
			wr(8'h0b, m);
			wr(8'h0c, h);
			cmp("b_lines", {1'b0, m[0], l[7:6], h[2], l[4:2]}, {1'b0, chan_b_line_off});
			cmp("a_lines", {1'b0, h[1:0], m[7], h[3], m[5:3]}, {1'b0, chan_a_line_off});
			cmp("frame", {7'h00, m[4]}, {7'h00, frame_clock_out_off});
			rd(8'h0b, m);
		end
		wr(8'h0b, 8'h10);
		wr(8'h0c, 8'h02);
		cmp("a_set", 8'h42, {1'b0, chan_a_line_off});
		cmp("frame_set", 8'h01, {7'h00, frame_clock_out_off});
		wr(8'h55, 8'hff);
		cmp("unmapped", 8'h42, {1'b0, chan_a_line_off});
		cmp("clk_idle", 8'h00, {6'h00, external_bit_clock_in_on, data_clock_out_off});
		wr(8'h1f, 8'h50);
		cmp("clk_ctl", 8'h03, {6'h00, external_bit_clock_in_on, data_clock_out_off});
	endtask : t_modes
	task automatic t_sleep;
		wr(8'h0d, 8'h08);
		wr(8'h08, 8'h01);
		@(negedge core_clk);
		cmp("spi_sleep", 8'h0a, {4'h0, offs});
		wr(8'h0d, 8'h06);
		@(negedge core_clk);
		cmp("held", 8'h0a, {4'h0, offs});
		rd(8'h0d, 8'h06);
		wr(8'h08, 8'h00);
		@(negedge core_clk);
		cmp("wake", 8'h00, {4'h0, offs});
		sync_or_sleep_pin = 1;
		repeat (2) @(negedge core_clk);
		cmp("pin_sleep", 8'h0d, {4'h0, offs});
		sync_or_sleep_pin = 0;
		repeat (2) @(negedge core_clk);
	endtask : t_sleep
	task automatic t_sync;
		logic [3:0] n;
		wr(8'h0e, 8'h80);
		sync_or_sleep_pin = 1;
		n = 0;
		repeat (4) @(negedge core_clk) n += 4'(sync_pulse);
		cmp("sync", 8'h10, {n, offs});
		sync_or_sleep_pin = 0;
	endtask : t_sync
	task automatic wrap_up;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (16) @(negedge core_clk);
		rst_n = 1;
		t_reset();
		t_modes();
		t_sleep();
		t_sync();
		wrap_up();
	end
	// The tests need well under 200 cycles, so this span only trips on a hang.
	initial begin
		#100000;
		err_count++;
		wrap_up();
	end
endmodule : tb
